// ==== inc/acm_pkg.sv ====
// Constants, register map and types for the converter output-mode block.
// Assumes a 100 MHz system clock sampling the converter's sample clock pin.
package acm_pkg;
    localparam int CODE_W = 14;
    localparam int PIPE_STAGES = 6;

    // Four-level format pin, already resolved to two bits by the pad
    localparam logic [1:0] MODE_GND = 2'h0;
    localparam logic [1:0] MODE_THIRD = 2'h1;
    localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
    localparam logic [1:0] MODE_VDD = 2'h3;

    // Timing, in the system clock
    localparam int CLK_PERIOD_PS = 10000;
    localparam int MIN_PHASE_PS = 5900;
    localparam int MIN_PERIOD_PS = 12500;
    localparam int MAX_PERIOD_NS = 1000;
    localparam int STOP_NS = 10000;
    localparam int SLEEP_WAKE_NS = 1000000;
    localparam logic [15:0] MIN_PHASE_CYC =
        16'((MIN_PHASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [15:0] MIN_PERIOD_CYC =
        16'((MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [15:0] MAX_PERIOD_CYC =
        16'(MAX_PERIOD_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [15:0] STOP_CYC = 16'(STOP_NS * 1000 / CLK_PERIOD_PS);
    localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_NS / (CLK_PERIOD_PS / 1000);

    // Sample clock edge counts
    localparam logic [7:0] DCS_LOCK_EDGES = 8'h64;
    localparam logic [7:0] NAP_WAKE_EDGES = 8'h64;

    // Duty windows in percent, stabiliser off and on
    localparam logic [31:0] DUTY_LO_OFF = 32'h2d;
    localparam logic [31:0] DUTY_HI_OFF = 32'h37;
    localparam logic [31:0] DUTY_LO_DCS = 32'h28;
    localparam logic [31:0] DUTY_HI_DCS = 32'h3c;
    localparam logic [31:0] PERCENT = 32'h64;

    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0c;
    localparam logic [7:0] REG_FAULT = 8'h10;
    localparam int CTRL_SOFT_DIS = 0;
    localparam int CTRL_CNT_CLR = 1;
    localparam int FLT_DUTY = 0;
    localparam int FLT_FAST = 1;
    localparam int FLT_SLOW = 2;
    localparam int FLT_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ACM_RUN = 3'h0,
        ACM_NAP = 3'h1,
        ACM_SLEEP = 3'h2,
        ACM_WAKE_NAP = 3'h3,
        ACM_WAKE_SLEEP = 3'h4
    } acm_pwr_e;
endpackage

// ==== verilog/acm_pipe_mem.sv ====
// Delay line standing in for the converter's pipelined stages.
// Assumes shift_en pulses once per sample; dout is a register.
`timescale 1ns/1ps
module acm_pipe_mem #(
    parameter int W = 15,
    parameter int DEPTH = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic shift_en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] mem_reg [DEPTH];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (shift_en) begin
            mem_reg[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                mem_reg[i] <= mem_reg[i-1];
            end
        end
    end

    assign dout = mem_reg[DEPTH-1];
endmodule

// ==== verilog/acm_top.sv ====
// Output-mode control of a pipelined 14-bit sampling converter.
// Assumes all pins are asynchronous to aclk; software on AXI4-Lite.
// Notes on behaviour
// - Format pin ground or third: offset binary
// - Format pin two-thirds or supply: two's complement
// - Stabiliser on only at intermediate format levels
// - Stabiliser: rising edge samples, falling ignored
// - Stabiliser accepts 40 to 60 percent duty
// - Hundred edges relock after long clock stop
// - Flag high when input beyond range limits
// - Output-disable high floats data and flag
// - Power-down low means normal conversion
// - Power-down with disable: sleep, milliseconds recovery
// - Power-down without disable: nap, 100-cycle recovery
// - Sleep and nap float data and flag
// - Result appears six sample clocks later
// - Track while low, hold at rising edge
`timescale 1ns/1ps
module acm_top #(
    parameter int SLEEP_WAKE_CYCLES = acm_pkg::SLEEP_WAKE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sample_clk_pin,
    input wire logic [1:0] mode_pin,
    input wire logic power_down_pin,
    input wire logic output_disable_pin,
    input wire logic [acm_pkg::CODE_W-1:0] analog_code,
    input wire logic over_range_pin,
    input wire logic under_range_pin,
    output logic [acm_pkg::CODE_W-1:0] result_data,
    output logic result_data_oe,
    output logic range_exceeded_flag,
    output logic range_exceeded_flag_oe,
    output logic result_update,
    output logic result_valid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int CW = acm_pkg::CODE_W;

    function automatic logic mode_dcs(input logic [1:0] m);
        mode_dcs = (m == acm_pkg::MODE_THIRD) ||
                   (m == acm_pkg::MODE_TWO_THIRDS);
    endfunction

    function automatic logic mode_twos(input logic [1:0] m);
        mode_twos = (m == acm_pkg::MODE_TWO_THIRDS) ||
                    (m == acm_pkg::MODE_VDD);
    endfunction

    function automatic logic duty_bad(input logic [15:0] hi,
                                      input logic [15:0] per,
                                      input logic [31:0] lo_pct,
                                      input logic [31:0] hi_pct);
        logic [31:0] h;
        logic [31:0] p;
        h = {16'h0000, hi} * acm_pkg::PERCENT;
        p = {16'h0000, per};
        duty_bad = (h < p * lo_pct) || (h > p * hi_pct);
    endfunction

    // Pin synchronisers: the first stage feeds only the second
    logic [CW+6:0] pin_s1_reg;
    logic [CW+6:0] pin_s2_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {sample_clk_pin, mode_pin, power_down_pin,
                           output_disable_pin, analog_code,
                           over_range_pin, under_range_pin};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic sclk_s;
    logic [1:0] mode_s;
    logic pdn_s;
    logic odis_s;
    logic [CW-1:0] code_s;
    logic over_s;
    logic under_s;
    assign {sclk_s, mode_s, pdn_s, odis_s, code_s, over_s, under_s} =
        pin_s2_reg;

    logic sclk_d_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end
    wire rise = sclk_s && !sclk_d_reg;
    wire fall = !sclk_s && sclk_d_reg;
    wire dcs_on = mode_dcs(mode_s);

    // Phase timing monitor for the sample clock
    logic [15:0] hi_cnt_reg;
    logic [15:0] lo_cnt_reg;
    logic [15:0] hi_last_reg;
    logic [15:0] idle_cnt_reg;
    logic have_hi_reg;
    logic [acm_pkg::FLT_W-1:0] fault_reg;
    logic [acm_pkg::FLT_W-1:0] fault_set;
    logic [acm_pkg::FLT_W-1:0] fault_clr;
    wire stopped = idle_cnt_reg >= acm_pkg::STOP_CYC;
    wire [15:0] period = hi_last_reg + lo_cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt_reg <= '0;
            lo_cnt_reg <= '0;
            hi_last_reg <= '0;
            idle_cnt_reg <= acm_pkg::STOP_CYC;
            have_hi_reg <= 1'b0;
        end else begin
            if (rise) begin
                hi_cnt_reg <= 16'h0001;
                idle_cnt_reg <= '0;
            end else begin
                if (sclk_s && hi_cnt_reg != 16'hffff) begin
                    hi_cnt_reg <= hi_cnt_reg + 16'h0001;
                end
                if (!stopped) begin
                    idle_cnt_reg <= idle_cnt_reg + 16'h0001;
                end
            end
            if (fall) begin
                lo_cnt_reg <= 16'h0001;
                hi_last_reg <= hi_cnt_reg;
                have_hi_reg <= !stopped;
            end else if (!sclk_s && lo_cnt_reg != 16'hffff) begin
                lo_cnt_reg <= lo_cnt_reg + 16'h0001;
            end
        end
    end

    // Checks on the clock source; a stop resets the measurement
    always_comb begin
        fault_set = '0;
        // Stabiliser skips the minimum-phase check at the incoming falling edge
        if (fall && !dcs_on && hi_cnt_reg < acm_pkg::MIN_PHASE_CYC) begin
            fault_set[acm_pkg::FLT_DUTY] = 1'b1;
        end
        if (rise && have_hi_reg && !stopped) begin
            if (!dcs_on && lo_cnt_reg < acm_pkg::MIN_PHASE_CYC) begin
                fault_set[acm_pkg::FLT_DUTY] = 1'b1;
            end
            if (dcs_on) begin
                if (duty_bad(hi_last_reg, period, acm_pkg::DUTY_LO_DCS,
                             acm_pkg::DUTY_HI_DCS)) begin
                    fault_set[acm_pkg::FLT_DUTY] = 1'b1;
                end
            end else if (duty_bad(hi_last_reg, period,
                                  acm_pkg::DUTY_LO_OFF,
                                  acm_pkg::DUTY_HI_OFF)) begin
                fault_set[acm_pkg::FLT_DUTY] = 1'b1;
            end
            if (period < acm_pkg::MIN_PERIOD_CYC) begin
                fault_set[acm_pkg::FLT_FAST] = 1'b1;
            end
            if (period > acm_pkg::MAX_PERIOD_CYC) begin
                fault_set[acm_pkg::FLT_SLOW] = 1'b1;
            end
        end
    end

    // Stabiliser lock: restarts after a long stop or on enabling
    logic [7:0] lock_cnt_reg;
    logic dcs_prev_reg;
    wire locked = lock_cnt_reg >= acm_pkg::DCS_LOCK_EDGES;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_reg <= '0;
            dcs_prev_reg <= 1'b0;
        end else begin
            dcs_prev_reg <= dcs_on;
            if ((dcs_on && !dcs_prev_reg) || (stopped && !rise)) begin
                lock_cnt_reg <= '0;
            end else if (rise && !locked) begin
                lock_cnt_reg <= lock_cnt_reg + 8'h01;
            end
        end
    end

    // Power state
    acm_pkg::acm_pwr_e pwr_reg;
    logic [31:0] wake_cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_reg <= acm_pkg::ACM_RUN;
            wake_cnt_reg <= '0;
        end else if (pdn_s) begin
            wake_cnt_reg <= '0;
            pwr_reg <= odis_s ? acm_pkg::ACM_SLEEP
                              : acm_pkg::ACM_NAP;
        end else begin
            case (pwr_reg)
                acm_pkg::ACM_RUN: begin
                    wake_cnt_reg <= '0;
                end
                acm_pkg::ACM_NAP: begin
                    pwr_reg <= acm_pkg::ACM_WAKE_NAP;
                end
                acm_pkg::ACM_SLEEP: begin
                    pwr_reg <= acm_pkg::ACM_WAKE_SLEEP;
                end
                acm_pkg::ACM_WAKE_NAP: begin
                    if (rise) begin
                        wake_cnt_reg <= wake_cnt_reg + 32'h1;
                    end
                    if (wake_cnt_reg >= {24'h0, acm_pkg::NAP_WAKE_EDGES}) begin
                        pwr_reg <= acm_pkg::ACM_RUN;
                    end
                end
                acm_pkg::ACM_WAKE_SLEEP: begin
                    wake_cnt_reg <= wake_cnt_reg + 32'h1;
                    if (wake_cnt_reg >= 32'(SLEEP_WAKE_CYCLES)) begin
                        pwr_reg <= acm_pkg::ACM_RUN;
                    end
                end
                default: begin
                    pwr_reg <= acm_pkg::ACM_RUN;
                end
            endcase
        end
    end
    wire asleep = (pwr_reg == acm_pkg::ACM_NAP) ||
                  (pwr_reg == acm_pkg::ACM_SLEEP);

    // Conversion pipeline: sample held at the rising edge
    wire convert = rise && !asleep && !pdn_s;
    logic [CW:0] pipe_in;
    logic [CW:0] pipe_out;
    always_comb begin
        pipe_in[CW] = over_s || under_s;
        pipe_in[CW-1:0] = code_s;
        if (mode_twos(mode_s)) begin
            pipe_in[CW-1] = !code_s[CW-1];
        end
    end

    acm_pipe_mem #(
        .W(CW + 1),
        .DEPTH(acm_pkg::PIPE_STAGES)
    ) u_pipe (
        .aclk(aclk),
        .aresetn(aresetn),
        .shift_en(convert),
        .din(pipe_in),
        .dout(pipe_out)
    );

    // Fill count: results are trusted once six samples have passed
    logic [7:0] fill_cnt_reg;
    logic soft_dis_reg;
    wire trust = !dcs_on || locked;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_cnt_reg <= '0;
        end else if (asleep || (dcs_on && !locked)) begin
            fill_cnt_reg <= '0;
        end else if (convert && fill_cnt_reg != 8'(acm_pkg::PIPE_STAGES)) begin
            fill_cnt_reg <= fill_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_data <= '0;
            range_exceeded_flag <= 1'b0;
            result_update <= 1'b0;
            result_valid <= 1'b0;
        end else begin
            result_update <= convert;
            if (convert) begin
                result_data <= pipe_out[CW-1:0];
                range_exceeded_flag <= pipe_out[CW];
            end
            result_valid <= trust && pwr_reg == acm_pkg::ACM_RUN && !pdn_s &&
                fill_cnt_reg == 8'(acm_pkg::PIPE_STAGES);
        end
    end

    // Output drivers float while disabled or powered down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_data_oe <= 1'b0;
            range_exceeded_flag_oe <= 1'b0;
        end else begin
            result_data_oe <= !odis_s && !soft_dis_reg &&
                              !asleep && !pdn_s;
            range_exceeded_flag_oe <= !odis_s && !soft_dis_reg &&
                                      !asleep && !pdn_s;
        end
    end

    // Register slave
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [31:0] sample_cnt_reg;
    wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire wr_ctrl = do_write && awaddr_reg == acm_pkg::REG_CTRL &&
                   wstrb_reg[0];
    wire wr_fault = do_write && awaddr_reg == acm_pkg::REG_FAULT &&
                    wstrb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= acm_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg == acm_pkg::REG_CTRL ||
                                awaddr_reg == acm_pkg::REG_FAULT)
                               ? acm_pkg::RESP_OKAY : acm_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Soft disable adds to the pin; both are slow controls, not per-sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_dis_reg <= 1'b0;
        end else if (wr_ctrl) begin
            soft_dis_reg <= wdata_reg[acm_pkg::CTRL_SOFT_DIS];
        end
    end

    // Sticky faults, write one to clear; a new event wins over the clear
    assign fault_clr = wr_fault ? wdata_reg[acm_pkg::FLT_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= (fault_reg & ~fault_clr) | fault_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_cnt_reg <= '0;
        end else if (convert) begin
            sample_cnt_reg <= sample_cnt_reg + 32'h1;
        end else if (wr_ctrl && wdata_reg[acm_pkg::CTRL_CNT_CLR]) begin
            sample_cnt_reg <= '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= acm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= acm_pkg::RESP_OKAY;
            case (s_axi_araddr)
                acm_pkg::REG_CTRL: s_axi_rdata <= {31'h0, soft_dis_reg};
                acm_pkg::REG_STATUS: s_axi_rdata <= {25'h0, result_valid,
                    pwr_reg, mode_twos(mode_s), locked, dcs_on};
                acm_pkg::REG_COUNT: s_axi_rdata <= sample_cnt_reg;
                acm_pkg::REG_RESULT: s_axi_rdata <= {17'h0,
                    range_exceeded_flag, result_data};
                acm_pkg::REG_FAULT: s_axi_rdata <= {29'h0, fault_reg};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= acm_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ==== test/acm_top_sva.sv ====
// Pin-level assertions for the converter output-mode block.
// Assumes binding onto acm_top; sees its ports only.
`timescale 1ns/1ps
module acm_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_down_pin,
    input wire logic output_disable_pin,
    input wire logic [acm_pkg::CODE_W-1:0] result_data,
    input wire logic result_data_oe,
    input wire logic range_exceeded_flag,
    input wire logic range_exceeded_flag_oe,
    input wire logic result_update,
    input wire logic result_valid
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_dis_float: assert property (output_disable_pin [*5] |-> !result_data_oe)
        else $error("data pins driven while disabled");
    a_oe_pair: assert property (result_data_oe == range_exceeded_flag_oe)
        else $error("flag enable differs from data enable");
    a_pd_float: assert property (power_down_pin [*5] |->
        !result_data_oe && !range_exceeded_flag_oe)
        else $error("outputs driven while powered down");
    a_pd_frozen: assert property (power_down_pin [*6] |-> !result_update)
        else $error("conversion while powered down");
    a_pd_invalid: assert property (power_down_pin [*6] |-> !result_valid)
        else $error("results marked valid while powered down");
    a_upd_pulse: assert property (result_update |=> !result_update)
        else $error("update longer than one cycle");
    a_data_move: assert property ($changed(result_data) |-> result_update)
        else $error("data changed without update");
    a_flag_move: assert property ($changed(range_exceeded_flag) |-> result_update)
        else $error("flag changed apart from its word");
endmodule

bind acm_top acm_top_sva u_sva (.aclk, .aresetn, .power_down_pin,
    .output_disable_pin, .result_data, .result_data_oe, .range_exceeded_flag,
    .range_exceeded_flag_oe, .result_update, .result_valid);

// ==== test/acm_latch.sv ====
// Downstream latch capturing the parallel word on each update.
// Assumes strobe is the one-cycle update pulse of the block.
`timescale 1ns/1ps
module acm_latch (
    input wire logic aclk,
    input wire logic [acm_pkg::CODE_W-1:0] data,
    input wire logic data_oe,
    input wire logic flag,
    input wire logic flag_oe,
    input wire logic strobe,
    output logic [acm_pkg::CODE_W-1:0] held,
    output logic held_flag
);
    // Floating pins read as the inverse, so a stale word never passes
    logic [acm_pkg::CODE_W-1:0] pins;
    logic flag_pin;
    assign pins = data_oe ? data : ~held;
    assign flag_pin = flag_oe ? flag : ~held_flag;
    always_ff @(posedge aclk) begin
        if (strobe) begin
            held <= pins;
            held_flag <= flag_pin;
        end
    end
endmodule

// ==== test/test_adc_output_mode_control.sv ====
// Self-checking bench for the converter output-mode block.
// Assumes acm_top, its checker and the downstream latch model.
`timescale 1ns/1ps
module test_adc_output_mode_control;
    logic aclk = 1'b0, aresetn = 1'b0, sample_clk_pin = 1'b0;
    logic [1:0] mode_pin = 2'h0;
    logic power_down_pin = 1'b0, output_disable_pin = 1'b0;
    logic [acm_pkg::CODE_W-1:0] analog_code = 14'h0000, result_data, held;
    logic over_range_pin = 1'b0, under_range_pin = 1'b0, held_flag;
    logic result_data_oe, range_exceeded_flag, range_exceeded_flag_oe;
    logic result_update, result_valid, s_axi_awready, s_axi_wready;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int err_total = 0;
    int comparisons = 0;

    always #5 aclk = ~aclk;

    // Short sleep recovery keeps the run brief
    acm_top #(.SLEEP_WAKE_CYCLES(50)) uut (.*);
    acm_latch u_latch (.aclk(aclk), .data(result_data),
        .data_oe(result_data_oe), .flag(range_exceeded_flag),
        .flag_oe(range_exceeded_flag_oe), .strobe(result_update),
        .held(held), .held_flag(held_flag));

    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 64) begin
            err_total++;
            print_verdict();
        end
    endtask

    // 80 ns period, even halves: 12.5 Msps, well inside the legal span
    task automatic pulse(input int k);
        repeat (k) begin
            sample_clk_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            sample_clk_pin <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, acm_pkg::RESP_OKAY);
        tmo(n);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask

    task automatic t_format(input logic [1:0] m);
        logic [13:0] v [12];
        logic [31:0] st;
        logic [1:0] rr;
        mode_pin <= m;
        repeat (4) @(posedge aclk);
        axi_rd(acm_pkg::REG_STATUS, st, rr);
        chk(st[0], m == 2'h1 || m == 2'h2);
        chk(st[2], m[1]);
        for (int i = 0; i < 12; i++) begin
            v[i] = 14'(i * 'h0a5b + m);
            analog_code <= v[i];
            over_range_pin <= (i % 3 == 1);
            under_range_pin <= (i % 3 == 2);
            pulse(1);
            if (i >= 6) begin
                chk(held, v[i-6] ^ {m[1], 13'h0});
                chk(held_flag, (i - 6) % 3 != 0);
            end
        end
        // Stabiliser modes are still relocking after only a dozen edges
        chk(result_valid, m == 2'h0 || m == 2'h3);
        axi_rd(acm_pkg::REG_RESULT, st, rr);
        chk(st, {17'h0, 1'b1, v[5] ^ {m[1], 13'h0}});
    endtask

    task automatic t_disable();
        logic [31:0] d;
        logic [1:0] r;
        output_disable_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(result_data_oe, 1'b0);
        chk(range_exceeded_flag_oe, 1'b0);
        output_disable_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(result_data_oe, 1'b1);
        axi_rd(acm_pkg::REG_COUNT, d, r);
        chk(d, 32'h30);
        axi_wr(acm_pkg::REG_CTRL, 32'h3);
        repeat (6) @(posedge aclk);
        chk(result_data_oe, 1'b0);
        axi_wr(acm_pkg::REG_CTRL, 32'h0);
        axi_rd(acm_pkg::REG_COUNT, d, r);
        chk(d, 32'h0);
        axi_rd(8'h20, d, r);
        chk(r, acm_pkg::RESP_SLVERR);
        chk(d, 32'h0);
    endtask

    task automatic t_power(input logic dis);
        logic [31:0] st;
        logic [1:0] r;
        power_down_pin <= 1'b1;
        output_disable_pin <= dis;
        repeat (6) @(posedge aclk);
        chk(range_exceeded_flag_oe, 1'b0);
        axi_rd(acm_pkg::REG_STATUS, st, r);
        chk(st[5:3], dis ? 3'h2 : 3'h1);
        chk(st[6], 1'b0);
        power_down_pin <= 1'b0;
        output_disable_pin <= 1'b0;
        if (dis) begin
            repeat (40) @(posedge aclk);
            chk(result_valid, 1'b0);
            pulse(16);
        end else begin
            pulse(99);
            chk(result_valid, 1'b0);
            pulse(20);
        end
        chk(result_valid, 1'b1);
        chk(result_data_oe, 1'b1);
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            t_format(2'(m));
        end
        t_disable();
        t_power(1'b0);
        t_power(1'b1);
        print_verdict();
    end
endmodule
